// >>> stepper_indexer_pkg.sv
// Constants shared by the stepper current indexer
package stepper_indexer_pkg;

  // ----------------------------------------------------------------
  // Electrical angle
  // ----------------------------------------------------------------
  localparam int POS_W = 7;
  localparam logic [6:0] INIT_POS = 7'h10;
  localparam logic [5:0] IDX_FULL = 6'h20;
  localparam logic [5:0] IDX_HALF_SUBST = 6'h10;
  localparam logic [5:0] IDX_QUARTER_SUBST = 6'h18;
  localparam logic [6:0] RATIO_FULL = 7'h64;
  localparam logic [6:0] RATIO_ZERO = 7'h00;

  // ----------------------------------------------------------------
  // Resolution select codes and step sizes
  // ----------------------------------------------------------------
  localparam logic [2:0] RES_IDLE = 3'h0;
  localparam logic [2:0] RES_FULL = 3'h1;
  localparam logic [2:0] RES_HALF_A = 3'h2;
  localparam logic [2:0] RES_QUARTER = 3'h3;
  localparam logic [2:0] RES_HALF_B = 3'h4;
  localparam logic [2:0] RES_EIGHTH = 3'h5;
  localparam logic [2:0] RES_SIXTEENTH = 3'h6;
  localparam logic [2:0] RES_THIRTYSECOND = 3'h7;
  localparam logic [6:0] STEP_FULL = 7'h20;
  localparam logic [6:0] STEP_HALF = 7'h10;
  localparam logic [6:0] STEP_QUARTER = 7'h08;
  localparam logic [6:0] STEP_EIGHTH = 7'h04;
  localparam logic [6:0] STEP_SIXTEENTH = 7'h02;
  localparam logic [6:0] STEP_THIRTYSECOND = 7'h01;

  // ----------------------------------------------------------------
  // Regulation target scaling: target = ref * 3 / 4 * ratio / 100
  // ----------------------------------------------------------------
  localparam int TARGET_NUM = 3;
  localparam int TARGET_DEN = 400;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h4;
  localparam logic [3:0] REG_STATE = 4'h8;
  localparam int EVT_W = 3;
  localparam int EVT_FAULT = 0;
  localparam int EVT_ALARM = 1;
  localparam int EVT_HOME = 2;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

endpackage : stepper_indexer_pkg

// >>> current_ratio_table.sv
// Current ratio lookup, percent of full current per table index
`timescale 1ns/1ps
module current_ratio_table
  import stepper_indexer_pkg::*;
(
  input wire logic [5:0] index,
  output logic [6:0] ratio
);

  always_comb
  begin
    unique case (index)
      6'd0: ratio = 7'd0;
      6'd1: ratio = 7'd5;
      6'd2: ratio = 7'd10;
      6'd3: ratio = 7'd15;
      6'd4: ratio = 7'd20;
      6'd5: ratio = 7'd25;
      6'd6: ratio = 7'd29;
      6'd7: ratio = 7'd34;
      6'd8: ratio = 7'd38;
      6'd9: ratio = 7'd43;
      6'd10: ratio = 7'd47;
      6'd11: ratio = 7'd52;
      6'd12: ratio = 7'd56;
      6'd13: ratio = 7'd60;
      6'd14: ratio = 7'd63;
      6'd15: ratio = 7'd67;
      6'd16: ratio = 7'd71;
      6'd17: ratio = 7'd74;
      6'd18: ratio = 7'd77;
      6'd19: ratio = 7'd80;
      6'd20: ratio = 7'd83;
      6'd21: ratio = 7'd86;
      6'd22: ratio = 7'd88;
      6'd23: ratio = 7'd90;
      6'd24: ratio = 7'd92;
      6'd25: ratio = 7'd94;
      6'd26: ratio = 7'd96;
      6'd27: ratio = 7'd97;
      6'd28: ratio = 7'd98;
      6'd29: ratio = 7'd99;
      6'd30: ratio = 7'd100;
      6'd31: ratio = 7'd100;
      6'd32: ratio = 7'd100;
      default: ratio = RATIO_ZERO;
    endcase
  end

endmodule : current_ratio_table

// >>> stepper_current_indexer.sv
// Step indexer: angle, channel currents, brake, flags and registers
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps

module stepper_current_indexer
  import stepper_indexer_pkg::*;
#(
  parameter int VREF_W = 8
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic step_clk,
  input wire logic direction_select,
  input wire logic [2:0] step_resolution_select,
  input wire logic brake,
  input wire logic angle_reset,
  input wire logic constant_voltage_mode,
  input wire logic [VREF_W-1:0] vref_level,
  input wire logic motor_power_good,
  input wire logic thermal_shutdown,
  input wire logic overcurrent_detect,
  input wire logic temp_alarm_detect,
  input wire logic temp_alarm_release,
  output logic [6:0] phase_a_ratio,
  output logic phase_a_negative,
  output logic [VREF_W-1:0] phase_a_target,
  output logic [6:0] phase_b_ratio,
  output logic phase_b_negative,
  output logic [VREF_W-1:0] phase_b_target,
  output logic regulation_enable,
  output logic phase_a_positive_output,
  output logic phase_a_negative_output,
  output logic phase_b_positive_output,
  output logic phase_b_negative_output,
  output logic low_power_idle,
  output logic home_angle_flag_out,
  output logic home_angle_flag_oe,
  output logic fault_flag_out,
  output logic fault_flag_oe,
  output logic thermal_alarm_flag_out,
  output logic thermal_alarm_flag_oe,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] step_size(input logic [2:0] res);
    logic [6:0] s;
    s = STEP_THIRTYSECOND;
    unique case (res)
      RES_IDLE, RES_FULL: s = STEP_FULL;
      RES_HALF_A, RES_HALF_B: s = STEP_HALF;
      RES_QUARTER: s = STEP_QUARTER;
      RES_EIGHTH: s = STEP_EIGHTH;
      RES_SIXTEENTH: s = STEP_SIXTEENTH;
      RES_THIRTYSECOND: s = STEP_THIRTYSECOND;
    endcase
    return s;
  endfunction : step_size

  // Table entries replaced by full current in the full, half (code 2 only) and quarter modes
  function automatic logic [6:0] adjust_ratio(input logic [5:0] idx,
                                              input logic [6:0] raw,
                                              input logic [2:0] res);
    logic [6:0] r;
    r = raw;
    if ((res == RES_FULL || res == RES_HALF_A) && idx == IDX_HALF_SUBST)
      r = RATIO_FULL;
    if (res == RES_QUARTER && idx == IDX_QUARTER_SUBST)
      r = RATIO_FULL;
    return r;
  endfunction : adjust_ratio

  function automatic logic [VREF_W-1:0] scale_target(
      input logic [VREF_W-1:0] vref, input logic [6:0] ratio);
    logic [VREF_W+9:0] prod;
    prod = (VREF_W + 10)'(vref) * (VREF_W + 10)'(TARGET_NUM)
           * (VREF_W + 10)'(ratio);
    return VREF_W'(prod / (VREF_W + 10)'(TARGET_DEN));
  endfunction : scale_target

  // ----------------------------------------------------------------
  // Electrical angle
  // ----------------------------------------------------------------
  logic [6:0] position;
  logic [6:0] next_position;
  logic step_prev;
  logic next_step_prev;
  logic idle;

  assign idle = (step_resolution_select == RES_IDLE);

  always_comb
  begin
    next_step_prev = step_clk;
    next_position = position;
    if (angle_reset || idle)
      next_position = INIT_POS;
    else if (step_clk && !step_prev)
    begin
      if (direction_select)
        next_position = position + step_size(step_resolution_select);
      else
        next_position = position - step_size(step_resolution_select);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      position <= INIT_POS;
      step_prev <= 1'b0;
    end
    else
    begin
      position <= next_position;
      step_prev <= next_step_prev;
    end
  end

  // ----------------------------------------------------------------
  // Channel magnitude and sign: A follows cosine, B sine
  // ----------------------------------------------------------------
  logic [1:0] quadrant;
  logic [5:0] offset;
  logic [5:0] idx_a;
  logic [5:0] idx_b;
  logic [6:0] raw_a;
  logic [6:0] raw_b;
  logic neg_a;
  logic neg_b;

  assign quadrant = position[6:5];
  assign offset = {1'b0, position[4:0]};
  assign idx_a = quadrant[0] ? offset : IDX_FULL - offset;
  assign idx_b = quadrant[0] ? IDX_FULL - offset : offset;
  assign neg_a = quadrant[0] ^ quadrant[1];
  assign neg_b = quadrant[1];

  current_ratio_table u_table_a (
    .index(idx_a),
    .ratio(raw_a)
  );

  current_ratio_table u_table_b (
    .index(idx_b),
    .ratio(raw_b)
  );

  // ----------------------------------------------------------------
  // Brake sign capture and drive outputs
  // ----------------------------------------------------------------
  logic brake_prev;
  logic held_neg_a;
  logic held_neg_b;
  logic next_brake_prev;
  logic next_held_neg_a;
  logic next_held_neg_b;
  logic [6:0] ratio_a;
  logic [6:0] ratio_b;
  logic cur_neg_a;
  logic cur_neg_b;
  logic [3:0] windings;

  always_comb
  begin
    next_brake_prev = brake;
    next_held_neg_a = held_neg_a;
    next_held_neg_b = held_neg_b;
    if (brake && !brake_prev)
    begin
      next_held_neg_a = neg_a;
      next_held_neg_b = neg_b;
    end
    ratio_a = adjust_ratio(idx_a, raw_a, step_resolution_select);
    ratio_b = adjust_ratio(idx_b, raw_b, step_resolution_select);
    cur_neg_a = neg_a;
    cur_neg_b = neg_b;
    // Brake mode depends on the regulation style
    if (brake && !constant_voltage_mode)
    begin
      ratio_a = RATIO_FULL;
      ratio_b = RATIO_FULL;
      cur_neg_a = brake_prev ? held_neg_a : neg_a;
      cur_neg_b = brake_prev ? held_neg_b : neg_b;
    end
    windings = {ratio_b != RATIO_ZERO && cur_neg_b,
                ratio_b != RATIO_ZERO && !cur_neg_b,
                ratio_a != RATIO_ZERO && cur_neg_a,
                ratio_a != RATIO_ZERO && !cur_neg_a};
    if (brake && constant_voltage_mode)
      windings = 4'hF;
    if (idle)
      windings = 4'h0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      brake_prev <= 1'b0;
      held_neg_a <= 1'b0;
      held_neg_b <= 1'b0;
      phase_a_ratio <= RATIO_ZERO;
      phase_b_ratio <= RATIO_ZERO;
      phase_a_negative <= 1'b0;
      phase_b_negative <= 1'b0;
      phase_a_target <= '0;
      phase_b_target <= '0;
      regulation_enable <= 1'b0;
      {phase_b_negative_output, phase_b_positive_output,
       phase_a_negative_output, phase_a_positive_output} <= 4'h0;
      low_power_idle <= 1'b1;
    end
    else
    begin
      brake_prev <= next_brake_prev;
      held_neg_a <= next_held_neg_a;
      held_neg_b <= next_held_neg_b;
      phase_a_ratio <= ratio_a;
      phase_b_ratio <= ratio_b;
      phase_a_negative <= cur_neg_a;
      phase_b_negative <= cur_neg_b;
      phase_a_target <= scale_target(vref_level, ratio_a);
      phase_b_target <= scale_target(vref_level, ratio_b);
      regulation_enable <= !constant_voltage_mode && !idle;
      {phase_b_negative_output, phase_b_positive_output,
       phase_a_negative_output, phase_a_positive_output} <= windings;
      low_power_idle <= idle;
    end
  end

  // ----------------------------------------------------------------
  // Open-drain flags
  // ----------------------------------------------------------------
  logic fault_latch;
  logic alarm_latch;
  logic home_flag;
  logic next_fault_latch;
  logic next_alarm_latch;
  logic next_home_flag;

  always_comb
  begin
    next_home_flag = (next_position == INIT_POS);
    next_fault_latch = fault_latch;
    if (!motor_power_good || idle)
      next_fault_latch = 1'b0;
    if (thermal_shutdown || overcurrent_detect)
      next_fault_latch = 1'b1;
    next_alarm_latch = alarm_latch;
    if (temp_alarm_release)
      next_alarm_latch = 1'b0;
    if (temp_alarm_detect)
      next_alarm_latch = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_latch <= 1'b0;
      alarm_latch <= 1'b0;
      home_flag <= 1'b1;
    end
    else
    begin
      fault_latch <= next_fault_latch;
      alarm_latch <= next_alarm_latch;
      home_flag <= next_home_flag;
    end
  end

  assign home_angle_flag_out = 1'b0;
  assign home_angle_flag_oe = home_flag;
  assign fault_flag_out = 1'b0;
  assign fault_flag_oe = fault_latch;
  assign thermal_alarm_flag_out = 1'b0;
  assign thermal_alarm_flag_oe = alarm_latch;

  // ----------------------------------------------------------------
  // Register port and interrupt
  // ----------------------------------------------------------------
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] mask;
  logic [EVT_W-1:0] next_status;
  logic [EVT_W-1:0] next_mask;
  logic [EVT_W-1:0] events;
  logic [31:0] next_rdata;

  always_comb
  begin
    events = '0;
    events[EVT_FAULT] = next_fault_latch && !fault_latch;
    events[EVT_ALARM] = next_alarm_latch && !alarm_latch;
    events[EVT_HOME] = next_home_flag && !home_flag;
    next_status = status;
    next_mask = mask;
    if (reg_write && reg_addr == REG_STATUS)
      next_status = status & ~reg_wdata[EVT_W-1:0];
    if (reg_write && reg_addr == REG_MASK)
      next_mask = reg_wdata[EVT_W-1:0];
    // New events win over a clear in the same cycle
    next_status = next_status | events;
    next_rdata = RDATA_IDLE;
    if (reg_read)
    begin
      unique case (reg_addr)
        REG_STATUS: next_rdata = {29'h0, status};
        REG_MASK: next_rdata = {29'h0, mask};
        REG_STATE: next_rdata = {16'h0, alarm_latch, fault_latch,
                                 home_flag, low_power_idle, position,
                                 phase_b_negative, phase_a_negative,
                                 brake_prev, 2'b00};
        default: next_rdata = RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status <= STATUS_RESET;
      mask <= MASK_RESET;
      reg_rdata <= RDATA_IDLE;
    end
    else
    begin
      status <= next_status;
      mask <= next_mask;
      reg_rdata <= next_rdata;
    end
  end

  assign irq = |(status & mask);

endmodule : stepper_current_indexer

// >>> stepper_indexer_sva.sv
// Concurrent checks on the stepper indexer ports
`timescale 1ns/1ps
module stepper_indexer_chk
  import stepper_indexer_pkg::*;
#(
  parameter int VREF_W = 8
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [2:0] step_resolution_select,
  input wire logic brake,
  input wire logic angle_reset,
  input wire logic constant_voltage_mode,
  input wire logic [VREF_W-1:0] vref_level,
  input wire logic motor_power_good,
  input wire logic thermal_shutdown,
  input wire logic overcurrent_detect,
  input wire logic temp_alarm_detect,
  input wire logic temp_alarm_release,
  input wire logic [6:0] phase_a_ratio,
  input wire logic phase_a_negative,
  input wire logic [VREF_W-1:0] phase_a_target,
  input wire logic [6:0] phase_b_ratio,
  input wire logic phase_b_negative,
  input wire logic phase_a_positive_output,
  input wire logic phase_a_negative_output,
  input wire logic phase_b_positive_output,
  input wire logic phase_b_negative_output,
  input wire logic low_power_idle,
  input wire logic home_angle_flag_oe,
  input wire logic fault_flag_oe,
  input wire logic thermal_alarm_flag_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic run;
  logic cc_brk;
  logic [3:0] wind;
  logic [VREF_W-1:0] tgt_a;
  assign run = step_resolution_select != RES_IDLE;
  assign cc_brk = brake && !constant_voltage_mode && run && !angle_reset;
  assign wind = {phase_a_positive_output, phase_a_negative_output,
                 phase_b_positive_output, phase_b_negative_output};
  assign tgt_a = VREF_W'(int'(vref_level) * TARGET_NUM
                 * int'(phase_a_ratio) / TARGET_DEN);
  sequence cc_held;
    cc_brk [*3];
  endsequence
  sequence cv_held;
    (brake && constant_voltage_mode && run) [*3];
  endsequence
  a_fault_set: assert property ((thermal_shutdown || overcurrent_detect)
    |=> fault_flag_oe) else $error("fault flag not raised");
  a_fault_latch: assert property (fault_flag_oe && motor_power_good && run
    |=> fault_flag_oe) else $error("fault flag dropped");
  a_fault_clear: assert property ((!motor_power_good || !run)
    && !thermal_shutdown && !overcurrent_detect |=> !fault_flag_oe)
    else $error("fault flag not released");
  a_alarm_set: assert property (temp_alarm_detect
    |=> thermal_alarm_flag_oe) else $error("alarm not raised");
  a_alarm_clear: assert property (temp_alarm_release && !temp_alarm_detect
    |=> !thermal_alarm_flag_oe) else $error("alarm not released");
  a_cc_brake_full: assert property (cc_held |-> phase_a_ratio == RATIO_FULL
    && phase_b_ratio == RATIO_FULL) else $error("brake ratio not full");
  a_cc_brake_sign: assert property (cc_held ##1 cc_brk
    |-> $stable(phase_a_negative) && $stable(phase_b_negative))
    else $error("brake sign changed");
  a_cv_brake_on: assert property (cv_held |-> wind == 4'hf)
    else $error("windings not all on");
  a_idle_off: assert property ((!run) [*3] |-> low_power_idle
    && wind == 4'h0) else $error("idle outputs wrong");
  a_reset_home: assert property ((angle_reset && run) [*3]
    |-> home_angle_flag_oe && phase_a_ratio == phase_b_ratio)
    else $error("angle reset state wrong");
  a_target_scale: assert property (($stable(vref_level)
    && $stable(phase_a_ratio)) [*3] |-> phase_a_target == tgt_a)
    else $error("target scaling wrong");
endmodule : stepper_indexer_chk

bind stepper_current_indexer stepper_indexer_chk #(.VREF_W(VREF_W)) u_chk (
  .sys_clk, .rst_n, .step_resolution_select, .brake, .angle_reset,
  .constant_voltage_mode, .vref_level, .motor_power_good, .thermal_shutdown,
  .overcurrent_detect, .temp_alarm_detect, .temp_alarm_release,
  .phase_a_ratio, .phase_a_negative, .phase_a_target, .phase_b_ratio,
  .phase_b_negative, .phase_a_positive_output, .phase_a_negative_output,
  .phase_b_positive_output, .phase_b_negative_output, .low_power_idle,
  .home_angle_flag_oe, .fault_flag_oe, .thermal_alarm_flag_oe);

// >>> step_host.sv
// Host side model: step pulse source and open-drain pull-ups
`timescale 1ns/1ps
module step_host (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic step_go,
  input wire logic [2:0] od_out,
  input wire logic [2:0] od_oe,
  output logic step_clk,
  output logic [2:0] od_pin
);
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  // Each pulse is two cycles high then at least three low
  always_comb
  begin
    next_cnt = cnt;
    if (cnt != 3'h0)
      next_cnt = cnt - 3'h1;
    else if (step_go)
      next_cnt = 3'h4;
  end
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      cnt <= 3'h0;
    else
      cnt <= next_cnt;
  assign step_clk = cnt[2] || cnt == 3'h3;
  // Pull-up resistors on the three flag lines
  assign od_pin = (od_oe & od_out) | ~od_oe;
endmodule : step_host

// >>> tb_top.sv
// Self-checking bench for the stepper current indexer
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("[FAIL] %0t got %0h want %0h", $time, got, exp); \
    end \
  end
module tb_top;
  import stepper_indexer_pkg::*;
  logic sys_clk = 0, rst_n = 0, step_go = 0, direction_select = 1;
  logic [2:0] step_resolution_select = RES_THIRTYSECOND;
  logic brake = 0, angle_reset = 0, constant_voltage_mode = 0;
  logic [7:0] vref_level = 8'hc8;
  logic motor_power_good = 1, thermal_shutdown = 0, overcurrent_detect = 0;
  logic temp_alarm_detect = 0, temp_alarm_release = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rdv;
  logic reg_write = 0, reg_read = 0, irq, step_clk, regulation_enable;
  logic [6:0] phase_a_ratio, phase_b_ratio;
  logic [7:0] phase_a_target, phase_b_target;
  logic phase_a_negative, phase_b_negative, low_power_idle;
  wire logic [3:0] wind;
  wire logic [2:0] od_out, od_oe;
  logic [2:0] od_pin;
  int fails = 0, check_count = 0, cycles = 0;

  stepper_current_indexer DUT (.sys_clk, .rst_n, .step_clk, .direction_select,
    .step_resolution_select, .brake, .angle_reset, .constant_voltage_mode,
    .vref_level, .motor_power_good, .thermal_shutdown, .overcurrent_detect,
    .temp_alarm_detect, .temp_alarm_release, .phase_a_ratio, .phase_a_negative,
    .phase_a_target, .phase_b_ratio, .phase_b_negative, .phase_b_target,
    .regulation_enable, .phase_a_positive_output(wind[3]),
    .phase_a_negative_output(wind[2]), .phase_b_positive_output(wind[1]),
    .phase_b_negative_output(wind[0]), .low_power_idle,
    .home_angle_flag_out(od_out[0]), .home_angle_flag_oe(od_oe[0]),
    .fault_flag_out(od_out[1]), .fault_flag_oe(od_oe[1]),
    .thermal_alarm_flag_out(od_out[2]), .thermal_alarm_flag_oe(od_oe[2]),
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq);
  step_host u_host (.sys_clk, .rst_n, .step_go, .od_out, .od_oe, .step_clk,
    .od_pin);

  initial
    forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Bus, pin and step helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 rdv = reg_rdata;
  endtask : rd
  task automatic step(input logic dir, input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      direction_select <= dir;
      step_go <= 1'b1;
      @(posedge sys_clk);
      step_go <= 1'b0;
      cyc(4);
    end
  endtask : step
  task automatic ratios(input logic [6:0] a, input logic [6:0] b);
    #1;
    `CHK(phase_a_ratio, a)
    `CHK(phase_b_ratio, b)
  endtask : ratios
  task automatic pins(input logic [3:0] bw, input logic [3:0] lv);
    @(posedge sys_clk);
    {brake, constant_voltage_mode, thermal_shutdown, overcurrent_detect} <= bw;
    {temp_alarm_detect, temp_alarm_release, motor_power_good} <= lv[2:0];
    cyc(3);
    #1;
  endtask : pins
  task automatic home_pos(input logic [2:0] m);
    logic [6:0] e;
    e = (m == RES_FULL || m == RES_HALF_A) ? RATIO_FULL : 7'h47;
    @(posedge sys_clk);
    step_resolution_select <= m;
    angle_reset <= 1'b1;
    cyc(3);
    ratios(e, e);
    `CHK(od_pin[0], 1'b0)
    @(posedge sys_clk);
    angle_reset <= 1'b0;
  endtask : home_pos

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_state;
    rd(REG_STATE);
    `CHK(rdv[11:5], INIT_POS)
    `CHK(od_pin, 3'h6)
    rd(4'hc);
    `CHK(rdv, RDATA_IDLE)
  endtask : t_reset_state
  task automatic t_fine;
    step(1'b1, 1);
    ratios(7'h43, 7'h4a);
    `CHK(od_pin[0], 1'b1)
    step(1'b0, 2);
    ratios(7'h4a, 7'h43);
    step(1'b1, 1);
    ratios(7'h47, 7'h47);
    for (int m = 1; m < 8; m++) home_pos(3'(m));
    #1 `CHK(phase_a_target, 8'h6a)
    `CHK(phase_b_target, 8'h6a)
  endtask : t_fine
  task automatic t_coarse;
    home_pos(RES_QUARTER);
    step(1'b1, 1);
    ratios(7'h26, RATIO_FULL);
    pins(4'h8, 4'h1);
    ratios(RATIO_FULL, RATIO_FULL);
    step(1'b1, 1);
    rd(REG_STATE);
    `CHK(rdv[11:5], 7'h20)
    pins(4'h0, 4'h1);
    ratios(RATIO_ZERO, RATIO_FULL);
    step(1'b1, 6);
    `CHK({phase_a_negative, phase_b_negative}, 2'h3)
    pins(4'h8, 4'h1);
    ratios(RATIO_FULL, RATIO_FULL);
    `CHK({phase_a_negative, phase_b_negative}, 2'h3)
    pins(4'h0, 4'h1);
    home_pos(RES_HALF_A);
    step(1'b1, 1);
    ratios(RATIO_ZERO, RATIO_FULL);
    pins(4'h4, 4'h1);
    `CHK(wind, 4'h2)
    `CHK(regulation_enable, 1'b0)
    pins(4'hc, 4'h1);
    `CHK(wind, 4'hf)
    pins(4'h0, 4'h1);
    `CHK(regulation_enable, 1'b1)
  endtask : t_coarse
  task automatic t_flags;
    wr(REG_MASK, 32'h0000_0003);
    pins(4'h2, 4'h1);
    pins(4'h0, 4'h1);
    `CHK(od_pin[1], 1'b0)
    `CHK(irq, 1'b1)
    rd(REG_STATUS);
    `CHK(rdv[0], 1'b1)
    wr(REG_STATUS, 32'h0000_0007);
    pins(4'h0, 4'h1);
    `CHK({irq, od_pin[1]}, 2'h0)
    @(posedge sys_clk);
    step_resolution_select <= RES_IDLE;
    pins(4'h0, 4'h1);
    `CHK({od_pin[1], low_power_idle, wind}, 6'h30)
    @(posedge sys_clk);
    step_resolution_select <= RES_FULL;
    pins(4'h1, 4'h1);
    `CHK(od_pin[1], 1'b0)
    pins(4'h0, 4'h0);
    pins(4'h0, 4'h1);
    `CHK(od_pin[1], 1'b1)
    pins(4'h0, 4'h5);
    pins(4'h0, 4'h1);
    `CHK(od_pin[2], 1'b0)
    wr(REG_MASK, 32'h0000_0000);
    pins(4'h0, 4'h3);
    `CHK({irq, od_pin[2]}, 2'h1)
  endtask : t_flags

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    cyc(2);
    rst_n <= 1'b1;
    t_reset_state();
    t_fine();
    t_coarse();
    t_flags();
    tally_and_finish();
  end
endmodule : tb_top
